/* design/lcdfv_pkg.sv */
// package: register map, field layout and bus carriers of the frame fetch
package lcdfv_pkg;
   localparam int         REG_AW       = 12;
   localparam int         NREG         = 10;
   localparam int         IDX_W        = 4;
   // register byte offsets
   localparam logic [11:0] OFF_STATUS   = 12'h018;
   localparam logic [11:0] OFF_BASE     = 12'h100;
   localparam logic [11:0] OFF_LEN      = 12'h104;
   localparam logic [11:0] OFF_COUNT    = 12'h108;
   localparam logic [11:0] OFF_STRIDE   = 12'h10C;
   localparam logic [11:0] OFF_BUSCTL   = 12'h110;
   localparam logic [11:0] OFF_VPULSE   = 12'h200;
   localparam logic [11:0] OFF_VLEAD    = 12'h204;
   localparam logic [11:0] OFF_VVIS     = 12'h208;
   localparam logic [11:0] OFF_VTRAIL   = 12'h20C;
   // storage indices
   localparam logic [3:0]  IX_BASE      = 4'h0;
   localparam logic [3:0]  IX_LEN       = 4'h1;
   localparam logic [3:0]  IX_COUNT     = 4'h2;
   localparam logic [3:0]  IX_STRIDE    = 4'h3;
   localparam logic [3:0]  IX_BUSCTL    = 4'h4;
   localparam logic [3:0]  IX_VPULSE    = 4'h5;
   localparam logic [3:0]  IX_VLEAD     = 4'h6;
   localparam logic [3:0]  IX_VVIS      = 4'h7;
   localparam logic [3:0]  IX_VTRAIL    = 4'h8;
   localparam logic [3:0]  IX_STATUS    = 4'h9;
   localparam logic [3:0]  IX_NONE      = 4'hF;
   // writable bits per register kind
   localparam logic [31:0] MSK_ADDR     = 32'hFFFF_FFF8;
   localparam logic [31:0] MSK_12       = 32'h0000_0FFF;
   localparam logic [31:0] MSK_BUSCTL   = 32'h0000_0F1F;
   localparam logic [31:0] RST_BUSCTL   = 32'h0000_0408;
   localparam logic [31:0] RST_ZERO     = 32'h0000_0000;
   // bus options fields
   localparam int          LIM_LSB      = 8;
   localparam int          PERMIT_W     = 5;
   // event bit positions
   localparam int          EV_DONE      = 0;
   localparam int          EV_FAULT     = 1;
   localparam int          EV_VSYNC     = 2;
   localparam int          EV_STARVE    = 3;
   localparam logic [1:0]  RESP_OKAY    = 2'b00;
   localparam logic [1:0]  RESP_SLVERR  = 2'b10;
   localparam int          BEAT_SHIFT   = 3;

   typedef enum logic [1:0] {
      V_PULSE = 2'b00,
      V_LEAD  = 2'b01,
      V_VIS   = 2'b10,
      V_TRAIL = 2'b11
   } lcdfv_vstate_t;

   typedef struct packed {
      logic [31:0] addr;
      logic [7:0]  len;
   } lcdfv_ar_t;

   typedef struct packed {
      logic [63:0] data;
      logic [1:0]  resp;
      logic        last;
   } lcdfv_r_t;
endpackage : lcdfv_pkg

/* design/lcdfv_top.sv */
// frame fetch engine, vertical timing and register slave of the lcd path
// Operation
// - raise starve event when data enable is active without pixel data
// - after starve, drive default colour until frame ends, then resume
// - vertical sync event in the same cycle vsync output goes active
// - fetch fault event on any read error response
// - frame done event when last data of a frame arrives
// - fetch of the next frame begins at once after the last request
// - masked status is raw and mask; irq line high if any bit set
// - frame start address comes from bits 31:3, eight byte aligned
// - beats per line (eight bytes each) come from line length bits 31:3
// - lines per frame come from the 12-bit line count field
// - line start steps by signed two's complement stride
// - outstanding read requests never exceed the request limit
// - request limit zero stops new read requests; outstanding reads still complete
// - bursts of 16, 8, 4, 2, 1 beats, permitted sizes first, else the largest size that fits
// - line tail is finished with shorter bursts
// - no burst permitted behaves as all permitted
// - vsync lasts pulse field plus one line periods
// - lead blank lines equal field plus one after vsync
// - visible lines equal field plus one
// - trail blank lines equal field plus one before next vsync
// - pulse, lead, visible, trail repeat without gap
// - default colour when underrun or outside visible area
`timescale 1ns/1ps
`default_nettype none
module lcdfv_top
   import lcdfv_pkg::*;
#(
   parameter int PIX_W = 64
) (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic                   ce,
   input  wire logic [11:0]            s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   input  wire logic [11:0]            s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   output lcdfv_pkg::lcdfv_ar_t        fetch_ar,
   output logic                        fetch_arvalid,
   input  wire logic                   fetch_arready,
   input  wire lcdfv_pkg::lcdfv_r_t    fetch_r,
   input  wire logic                   fetch_rvalid,
   output logic                        fetch_rready,
   input  wire logic                   line_tick,
   input  wire logic                   h_active,
   input  wire logic [PIX_W-1:0]       default_word,
   input  wire logic [3:0]             raw_status,
   input  wire logic [3:0]             irq_mask,
   output logic                        vsync_out,
   output logic                        pixel_valid_out,
   output logic [PIX_W-1:0]            pixel_word_out,
   output logic [3:0]                  irq_src,
   output logic                        irq_out
);
   import lcdfv_pkg::*;

   // fetched beats are 64 bits, so the pixel word must match
   if (PIX_W != 64) begin : g_bad_pix_w
      $error("PIX_W must be 64");
   end

   function automatic logic [3:0] reg_index(input logic [11:0] a);
      case (a)
         OFF_BASE:   reg_index = IX_BASE;
         OFF_LEN:    reg_index = IX_LEN;
         OFF_COUNT:  reg_index = IX_COUNT;
         OFF_STRIDE: reg_index = IX_STRIDE;
         OFF_BUSCTL: reg_index = IX_BUSCTL;
         OFF_VPULSE: reg_index = IX_VPULSE;
         OFF_VLEAD:  reg_index = IX_VLEAD;
         OFF_VVIS:   reg_index = IX_VVIS;
         OFF_VTRAIL: reg_index = IX_VTRAIL;
         OFF_STATUS: reg_index = IX_STATUS;
         default:    reg_index = IX_NONE;
      endcase
   endfunction : reg_index

   function automatic logic [31:0] reg_mask(input logic [3:0] ix);
      case (ix)
         IX_BASE, IX_LEN, IX_STRIDE: reg_mask = MSK_ADDR;
         IX_BUSCTL:                  reg_mask = MSK_BUSCTL;
         default:                    reg_mask = MSK_12;
      endcase
   endfunction : reg_mask

   // largest permitted burst not past the line end, else largest burst not past it
   function automatic logic [4:0] pick_beats(input logic [28:0] left,
                                             input logic [4:0]  permit);
      logic [4:0] p;
      logic [4:0] b;
      p = (permit == 5'h00) ? 5'h1F : permit;
      b = 5'h00;
      for (int i = 0; i < PERMIT_W; i++) begin
         if (p[i] && left >= 29'(1 << i)) begin
            b = 5'(1 << i);
         end
      end
      if (b == 5'h00) begin
         for (int i = 0; i < PERMIT_W; i++) begin
            if (left >= 29'(1 << i)) begin
               b = 5'(1 << i);
            end
         end
      end
      pick_beats = b;
   endfunction : pick_beats

   logic [31:0]   regs_q [NREG-1];
   logic          aw_got_q;
   logic          w_got_q;
   logic [11:0]   aw_addr_q;
   logic [31:0]   w_data_q;
   logic [3:0]    w_strb_q;
   logic [3:0]    masked_q;
   logic [3:0]    wr_ix;
   logic [3:0]    rd_ix;
   logic [31:0]   wr_mask;

   // register write port
   assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
   assign wr_ix         = reg_index(aw_addr_q);
   assign rd_ix         = reg_index(s_axi_araddr);
   assign wr_mask       = reg_mask(wr_ix);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_q     <= 1'b0;
         w_got_q      <= 1'b0;
         aw_addr_q    <= 12'h000;
         w_data_q     <= 32'h0000_0000;
         w_strb_q     <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got_q  <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got_q  <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (aw_got_q && w_got_q) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_ix == IX_NONE) ? RESP_SLVERR : RESP_OKAY;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NREG - 1; i++) begin
            regs_q[i] <= (4'(i) == IX_BUSCTL) ? RST_BUSCTL : RST_ZERO;
         end
      end else if (ce && aw_got_q && w_got_q && wr_ix < IX_STATUS) begin
         for (int b = 0; b < 4; b++) begin
            if (w_strb_q[b]) begin
               regs_q[wr_ix][b*8 +: 8] <=
                  w_data_q[b*8 +: 8] & wr_mask[b*8 +: 8];
            end
         end
      end
   end

   // register read port
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OKAY;
      end else if (ce) begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OKAY;
            if (rd_ix == IX_STATUS) begin
               s_axi_rdata <= {28'h000_0000, masked_q};
            end else if (rd_ix == IX_NONE) begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= RESP_SLVERR;
            end else begin
               s_axi_rdata <= regs_q[rd_ix];
            end
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // masked status and interrupt line
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         masked_q <= 4'h0;
         irq_out  <= 1'b0;
      end else if (ce) begin
         masked_q <= raw_status & irq_mask;
         irq_out  <= |(raw_status & irq_mask);
      end
   end

   // fetch request side
   logic [28:0]   line_beats;
   logic [11:0]   line_total;
   logic [3:0]    req_limit;
   logic [28:0]   cur_addr_q;
   logic [28:0]   line_start_q;
   logic [28:0]   beats_left_q;
   logic [11:0]   lines_left_q;
   logic          run_q;
   logic [4:0]    outst_q;
   logic [4:0]    nb;
   logic          ar_load;
   logic          ar_fire;
   logic          r_fire;
   logic          cfg_ok;

   assign line_beats = regs_q[IX_LEN][31:BEAT_SHIFT];
   assign line_total = regs_q[IX_COUNT][11:0];
   assign req_limit  = regs_q[IX_BUSCTL][LIM_LSB +: 4];
   assign cfg_ok     = line_beats != 29'h0 && line_total != 12'h000;
   assign nb         = pick_beats(beats_left_q,
                                  regs_q[IX_BUSCTL][PERMIT_W-1:0]);
   assign ar_fire    = fetch_arvalid && fetch_arready;
   assign r_fire     = fetch_rvalid && fetch_rready;
   assign ar_load    = run_q && !fetch_arvalid &&
                       outst_q < {1'b0, req_limit};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         run_q         <= 1'b0;
         cur_addr_q    <= 29'h0;
         line_start_q  <= 29'h0;
         beats_left_q  <= 29'h0;
         lines_left_q  <= 12'h000;
         fetch_arvalid <= 1'b0;
         fetch_ar      <= '0;
      end else if (ce) begin
         if (ar_fire) begin
            fetch_arvalid <= 1'b0;
         end
         if (!run_q && cfg_ok) begin
            run_q        <= 1'b1;
            cur_addr_q   <= regs_q[IX_BASE][31:BEAT_SHIFT];
            line_start_q <= regs_q[IX_BASE][31:BEAT_SHIFT];
            beats_left_q <= line_beats;
            lines_left_q <= line_total;
         end else if (ar_load) begin
            fetch_arvalid <= 1'b1;
            fetch_ar.addr <= {cur_addr_q, 3'b000};
            fetch_ar.len  <= 8'(nb - 5'd1);
            if (beats_left_q == 29'(nb)) begin
               if (lines_left_q == 12'h001) begin
                  run_q <= 1'b0;
               end
               line_start_q <= line_start_q +
                               regs_q[IX_STRIDE][31:BEAT_SHIFT];
               cur_addr_q   <= line_start_q +
                               regs_q[IX_STRIDE][31:BEAT_SHIFT];
               beats_left_q <= line_beats;
               lines_left_q <= lines_left_q - 12'h001;
            end else begin
               cur_addr_q   <= cur_addr_q + 29'(nb);
               beats_left_q <= beats_left_q - 29'(nb);
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         outst_q <= 5'd0;
      end else if (ce) begin
         case ({ar_fire, r_fire && fetch_r.last})
            2'b10:   outst_q <= outst_q + 5'd1;
            2'b01:   outst_q <= outst_q - 5'd1;
            default: outst_q <= outst_q;
         endcase
      end
   end

   // vertical timing
   lcdfv_vstate_t vst_q;
   lcdfv_vstate_t vst_d;
   logic [11:0]   vcnt_q;
   logic [11:0]   vlim;
   logic          vstep;

   always_comb begin
      case (vst_q)
         V_PULSE: vlim = regs_q[IX_VPULSE][11:0];
         V_LEAD:  vlim = regs_q[IX_VLEAD][11:0];
         V_VIS:   vlim = regs_q[IX_VVIS][11:0];
         V_TRAIL: vlim = regs_q[IX_VTRAIL][11:0];
         default: vlim = 12'h000;
      endcase
   end

   assign vstep = ce && line_tick;

   always_comb begin
      vst_d = vst_q;
      if (vstep && vcnt_q == vlim) begin
         case (vst_q)
            V_PULSE: vst_d = V_LEAD;
            V_LEAD:  vst_d = V_VIS;
            V_VIS:   vst_d = V_TRAIL;
            V_TRAIL: vst_d = V_PULSE;
            default: vst_d = V_PULSE;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         vst_q     <= V_PULSE;
         vcnt_q    <= 12'h000;
         vsync_out <= 1'b1;
      end else if (vstep) begin
         vst_q     <= vst_d;
         vcnt_q    <= (vst_d != vst_q) ? 12'h000 : vcnt_q + 12'h001;
         vsync_out <= vst_d == V_PULSE;
      end
   end

   // pixel word holder and starve handling
   logic [PIX_W-1:0] word_q;
   logic             word_valid_q;
   logic             starve_q;
   logic             de_d;
   logic             consume;
   logic             new_frame;

   assign de_d      = vst_q == V_VIS && h_active;
   assign consume   = ce && de_d && word_valid_q && !starve_q;
   assign new_frame = vstep && vst_d == V_PULSE && vst_q != V_PULSE;
   assign fetch_rready = !word_valid_q || consume || starve_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         word_q          <= '0;
         word_valid_q    <= 1'b0;
         starve_q        <= 1'b0;
         pixel_valid_out <= 1'b0;
         pixel_word_out  <= '0;
      end else if (ce) begin
         pixel_valid_out <= de_d;
         if (r_fire && !starve_q) begin
            word_q       <= fetch_r.data;
            word_valid_q <= 1'b1;
         end else if (consume || starve_q) begin
            word_valid_q <= 1'b0;
         end
         if (new_frame) begin
            starve_q <= 1'b0;
         end else if (de_d && !word_valid_q) begin
            starve_q <= 1'b1;
         end
         pixel_word_out <= consume ? word_q : default_word;
      end
   end

   // event lines
   logic [28:0] rx_beat_q;
   logic [11:0] rx_line_q;
   logic        rx_end_beat;
   logic        rx_end_frame;

   assign rx_end_beat  = rx_beat_q + 29'h1 >= line_beats;
   assign rx_end_frame = rx_end_beat && rx_line_q + 12'h001 >= line_total;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rx_beat_q <= 29'h0;
         rx_line_q <= 12'h000;
      end else if (ce && r_fire) begin
         rx_beat_q <= rx_end_beat ? 29'h0 : rx_beat_q + 29'h1;
         if (rx_end_frame) begin
            rx_line_q <= 12'h000;
         end else if (rx_end_beat) begin
            rx_line_q <= rx_line_q + 12'h001;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_src <= 4'h0;
      end else if (ce) begin
         irq_src[EV_DONE]   <= r_fire && rx_end_frame;
         irq_src[EV_FAULT]  <= r_fire && fetch_r.resp[1];
         irq_src[EV_VSYNC]  <= new_frame;
         irq_src[EV_STARVE] <= de_d && !word_valid_q;
      end
   end

   // checks
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_starve;
      ce && vst_q == V_VIS && h_active && !word_valid_q;
   endsequence
   sequence s_pulse_end;
      vstep && vst_q == V_PULSE && vcnt_q == regs_q[IX_VPULSE][11:0];
   endsequence

   chk_starve_event: assert property (s_starve |=> irq_src[EV_STARVE])
      else $error("starve event missing");
   chk_starve_fill: assert property ((ce && (starve_q || !de_d))
      |=> pixel_word_out == $past(default_word))
      else $error("default colour not driven");
   chk_vsync_event: assert property ($rose(vsync_out) |-> irq_src[EV_VSYNC])
      else $error("vsync event not with vsync");
   chk_fault_event: assert property ((ce && r_fire && fetch_r.resp[1])
      |=> irq_src[EV_FAULT])
      else $error("fault event missing");
   chk_irq_line: assert property (ce |=> irq_out ==
      |($past(raw_status) & $past(irq_mask)))
      else $error("irq line mismatch");
   chk_req_limit: assert property ((ce && $rose(fetch_arvalid))
      |-> $past(outst_q) < {1'b0, $past(req_limit)})
      else $error("request over limit");
   chk_burst_size: assert property (fetch_arvalid
      |-> fetch_ar.len inside {8'd0, 8'd1, 8'd3, 8'd7, 8'd15})
      else $error("illegal burst length");
   chk_pulse_width: assert property (s_pulse_end
      |=> !vsync_out && vst_q == V_LEAD && vcnt_q == 12'h000)
      else $error("vsync width wrong");
   chk_ar_hold: assert property ((ce && fetch_arvalid && !fetch_arready)
      |=> fetch_arvalid && $stable(fetch_ar))
      else $error("read request dropped");
endmodule : lcdfv_top
`default_nettype wire

/* design/lcdfv_dummy_none.sv */
// intentionally empty holder file
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* test/lcdfv_mem_model.sv */
// read slave model standing in for the frame buffer memory
`timescale 1ns/1ps
`default_nettype none
module lcdfv_mem_model
   import lcdfv_pkg::*;
(
   input  wire logic      aclk,
   input  wire logic      aresetn,
   input  wire lcdfv_pkg::lcdfv_ar_t ar,
   input  wire logic      arvalid,
   output logic           arready,
   output lcdfv_pkg::lcdfv_r_t r,
   output logic           rvalid,
   input  wire logic      rready,
   input  wire logic      slow,
   input  wire logic      err_on
);
   lcdfv_ar_t  q[$];
   logic [7:0] beat;
   // in-order beats carrying their own address; idle data is scrambled
   always @(posedge aclk) begin
      if (!aresetn) begin
         q.delete();
         beat    <= 8'h00;
         arready <= 1'h0;
         rvalid  <= 1'h0;
         r       <= '0;
      end else begin
         arready <= !slow;
         if (arvalid && arready)
            q.push_back(ar);
         if (rvalid && rready) begin
            rvalid <= 1'h0;
            r.data <= ~r.data;
            beat   <= r.last ? 8'h00 : beat + 8'h01;
            if (r.last)
               void'(q.pop_front());
         end else if (!rvalid && q.size() != 0 && !slow) begin
            rvalid <= 1'h1;
            r.data <= {32'h0000_0000, q[0].addr + {21'h0, beat, 3'h0}};
            r.resp <= err_on ? RESP_SLVERR : RESP_OKAY;
            r.last <= (beat == q[0].len);
         end
      end
   end
endmodule : lcdfv_mem_model
`default_nettype wire

/* test/lcdfv_top_tb.sv */
// self-checking bench of the frame fetch and vertical timing block
`timescale 1ns/1ps
`default_nettype none
module lcdfv_top_tb;
   import lcdfv_pkg::*;
   localparam int          LP  = 4;
   localparam int          NB  = 5;
   localparam int          CNT = 3;
   // bus options first: limit is zero before a frame becomes valid
   localparam logic [11:0] OFS [9] = '{OFF_BUSCTL, OFF_BASE, OFF_LEN,
      OFF_COUNT, OFF_STRIDE, OFF_VPULSE, OFF_VLEAD, OFF_VVIS, OFF_VTRAIL};
   localparam logic [31:0] MS [9] = '{MSK_BUSCTL, MSK_ADDR, MSK_ADDR,
      MSK_12, MSK_ADDR, MSK_12, MSK_12, MSK_12, MSK_12};
   localparam logic [4:0]  PM [4] = '{5'h04, 5'h00, 5'h1F, 5'h03};
   localparam int          LM [4] = '{2, 1, 15, 4};
   logic        aclk, aresetn, awv, wv, arv, slow, err_on, line_tick;
   logic        h_active, awr, wrr, bv, arr, rv, fav, far, frv, frr;
   logic        vs, pv, irq, vs_q, stv, seen, vgo;
   logic [1:0]  bresp, rresp, ph, ok, rs;
   logic [3:0]  raw, msk, src, rm_q, rm2_q;
   logic [4:0]  perm;
   logic [11:0] awa, ara;
   logic [31:0] wd, rdt, sd, sm, bas, str, rdv;
   logic [31:0] fv [9];
   logic [63:0] dw, pw;
   lcdfv_ar_t   fa, xa;
   lcdfv_r_t    fr;
   int          num_errors, num_checks, cyc, p, b, v, f, hi, per, npv;
   int          oc, lim, ln, off, nbt, ndn, nft, nst, n;

   lcdfv_top uut (.aclk(aclk), .aresetn(aresetn), .ce(1'h1),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wrr), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(1'h1), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rresp),
      .s_axi_rvalid(rv), .s_axi_rready(1'h1), .fetch_ar(fa),
      .fetch_arvalid(fav), .fetch_arready(far), .fetch_r(fr),
      .fetch_rvalid(frv), .fetch_rready(frr), .line_tick(line_tick),
      .h_active(h_active), .default_word(dw), .raw_status(raw),
      .irq_mask(msk), .vsync_out(vs), .pixel_valid_out(pv),
      .pixel_word_out(pw), .irq_src(src), .irq_out(irq));
   lcdfv_mem_model mem (.aclk(aclk), .aresetn(aresetn), .ar(fa),
      .arvalid(fav), .arready(far), .r(fr), .rvalid(frv), .rready(frr),
      .slow(slow), .err_on(err_on));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   // largest allowed burst that fits, else largest power of two
   function automatic int pick(input int rem, input logic [4:0] pm);
      for (int i = 4; i >= 0; i--)
         if ((pm[i] || pm == 5'h00) && (1 << i) <= rem) return 1 << i;
      for (int i = 4; i >= 0; i--)
         if ((1 << i) <= rem) return 1 << i;
      return 1;
   endfunction : pick
   task automatic ck(input logic c, input string m);
      num_checks++;
      if (c !== 1'h1) begin
         num_errors++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : ck
   task automatic print_verdict();
      if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : print_verdict
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      awa <= a;
      wd <= d;
      awv <= 1'h1;
      wv <= 1'h1;
      do begin
         @(posedge aclk);
         if (awr) awv <= 1'h0;
         if (wrr) wv <= 1'h0;
      end while (bv !== 1'h1);
      rs = bresp;
   endtask : wr
   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      ara <= a;
      arv <= 1'h1;
      do begin
         @(posedge aclk);
         if (arr) arv <= 1'h0;
      end while (rv !== 1'h1);
      rdv = rdt;
      rs = rresp;
   endtask : rd

   initial begin
      aclk = 1'h0;
      forever #2.5 aclk = ~aclk;
   end
   // random side inputs, line period of LP cycles, hang limit
   always @(posedge aclk) begin
      sd = lfsr(sd);
      raw <= sd[3:0];
      msk <= sd[7:4];
      slow <= sd[8];
      ph <= ph + 2'h1;
      line_tick <= (ph == 2'h3);
      h_active <= ph[0] ^ ph[1];
      cyc++;
      if (cyc == 30000) begin
         num_errors++;
         print_verdict();
      end
   end
   always @(posedge aclk) begin
      ok <= {ok[0], aresetn};
      rm_q <= raw & msk;
      rm2_q <= rm_q;
      vs_q <= vs;
      if (ok[1]) begin
         ck(irq === |rm_q, "irq line");
         ck(src[2] === (vs & ~vs_q), "vsync flag");
         ck(pv === 1'h1 || pw === dw, "blank colour");
         ck(!stv || pw === dw, "starve colour");
         if (src[3]) stv = 1'h1;
         nst += src[3];
         nft += src[1];
         ndn += src[0];
         if (vs_q && !vs && seen) ck(hi === (p + 1) * LP, "pulse");
         if (vs && !vs_q) begin
            if (seen) ck(per === (p + b + v + f + 4) * LP, "frame");
            if (seen) ck(npv === 2 * (v + 1), "visible");
            {seen, stv, per, hi, npv} = {vgo, 1'h0, 96'h0};
         end
         per++;
         hi += vs;
         npv += pv;
         if (fav && far) begin
            ck(oc < lim, "outstanding");
            n = pick(NB - off, perm);
            xa = {bas + str * ln + 32'(off * 8), 8'(n - 1)};
            ck(fa === xa, "ar");
            oc++;
            off += n;
            if (off == NB) ln = (ln + 1) % CNT;
            if (off == NB) off = 0;
         end
         if (frv && frr) nbt++;
         if (frv && frr && fr.last) oc--;
      end
   end

   initial begin
      {awv, wv, arv, err_on, line_tick, h_active, slow, vgo, stv} = '0;
      {awa, ara, wd, raw, msk, ph, ok, perm} = '0;
      sd = 32'h6ec2_273d;
      sm = sd;
      dw = {sd, ~sd};
      aresetn = 1'h0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'h1;
      sm = lfsr(sm);
      {p, b, v, f} = {30'h0, sm[1:0], 30'h0, sm[3:2], 30'h0, sm[5:4],
         30'h0, sm[7:6]};
      bas = (sm & 32'h00FF_FFF8) | 32'h1000_0000;
      str = 32'hFFFF_FFC0;
      fv = '{32'h0000_0004, bas, 32'(NB * 8), 32'(CNT), str, 32'(p),
         32'(b), 32'(v), 32'(f)};
      for (int i = 0; i < 9; i++) begin
         rd(OFS[i]);
         ck(rdv === (i == 0 ? RST_BUSCTL : RST_ZERO), "reset value");
         sm = lfsr(sm);
         wr(OFS[i], (sm & ~MS[i]) | fv[i]);
         rd(OFS[i]);
         ck(rdv === fv[i], "read back");
      end
      wr(12'h7FC, sm);
      ck(rs === RESP_SLVERR, "unmapped write");
      rd(12'h7FC);
      ck(rs === RESP_SLVERR && rdv === 32'h0000_0000, "unmapped read");
      wr(OFF_STATUS, sm);
      ck(rs === RESP_OKAY, "status write");
      rd(OFF_STATUS);
      ck(rdv === {28'h000_0000, rm2_q} && rs === RESP_OKAY, "status");
      repeat (200) @(posedge aclk);
      vgo = 1'h1;
      for (int e = 0; e < 4; e++) begin
         if (e == 3) ck(nft === 0, "early fault");
         err_on <= (e == 3);
         perm = PM[e];
         lim = LM[e];
         wr(OFF_BUSCTL, {20'h0, 4'(LM[e]), 3'h0, PM[e]});
         repeat (300) @(posedge aclk);
         wr(OFF_BUSCTL, {27'h0, PM[e]});
         repeat (8) @(posedge aclk);
         while (oc != 0 || fav) @(posedge aclk);
         lim = 0;
         repeat (100) @(posedge aclk);
      end
      ck(ndn === nbt / (NB * CNT), "frame done count");
      ck(nft > 0, "fault flag");
      ck(nst > 0, "starve flag");
      print_verdict();
   end
endmodule : lcdfv_top_tb
`default_nettype wire
